// ---- design/flw_row_latch_writer.sv ----
// Flash row latch writer: AHB-Lite registers, unlock key, latch bank and row programming.
// Assumes one AHB-Lite master, single word transfers, and a flash array on the command port.
//
// Functional notes
// - Erase works on whole rows only
// - One program writes all 32 latches
// - Row from high address bits, latch from low
// - Programming never leaves the selected row
// - Latches return blank after each program or erase
// - Latch-only mode loads latch, no programming
// - Normal mode loads latch then programs row
// - Nothing starts without full unbroken unlock
// - Latch word taken when unlock completes
// - Protected target leaves start clear, sets refused flag
// - Stall during operation; done flag and interrupt
`timescale 1ns/100ps
module flw_row_latch_writer
    import flw_pkg::*;
#(
    parameter int OP_WAIT = FLW_OP_WAIT_CYCLES
)
(
    input wire logic hclk,                      // Bus clock
    input wire logic hresetn,                   // Async reset, low active
    input wire logic hsel,                      // Slave select
    input wire logic [FLW_HADDR_W-1:0] haddr,   // Byte address
    input wire logic [1:0] htrans,              // Transfer type
    input wire logic hwrite,                    // Write when high
    input wire logic [2:0] hsize,               // Transfer size, word only
    input wire logic hready,                    // Bus ready
    input wire logic [31:0] hwdata,             // Write data
    output logic [31:0] hrdata,                 // Read data
    output logic hreadyout,                     // Slave ready
    output logic hresp,                         // Always OKAY
    output logic irq,                           // Level interrupt
    output logic cpu_stall,                     // High while flash works
    output flw_flash_s flash_cmd                // Program or erase command
);

    flw_ph_s ph_q, ph_d;
    logic [FLW_ADDR_LOW_W-1:0] addr_low_q, addr_low_d;
    logic [FLW_ADDR_HIGH_W-1:0] addr_high_q, addr_high_d;
    logic [FLW_DATA_LOW_W-1:0] data_low_q, data_low_d;
    logic [FLW_DATA_HIGH_W-1:0] data_high_q, data_high_d;
    flw_ctl_s ctl_q, ctl_d;
    flw_key_e key_q, key_d;
    flw_state_e st_q, st_d;
    logic [FLW_LATCH_IDX_W-1:0] cnt_q, cnt_d;
    logic [FLW_WAIT_W-1:0] wait_q, wait_d;
    logic [FLW_ROW_W-1:0] row_q, row_d;
    logic [FLW_ROW_W-1:0] prot_q, prot_d;
    logic [FLW_IRQ_W-1:0] irq_st_q, irq_st_d;
    logic [FLW_IRQ_W-1:0] mask_q, mask_d;
    flw_flash_s flash_q, flash_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic hreadyout_q, hreadyout_d;
    logic hresp_q, hresp_d;
    logic irq_q, irq_d;
    logic stall_q, stall_d;
    logic wr_acc;
    logic trig;
    logic done_ev;
    logic refuse_ev;
    logic mem_we;
    logic mem_clear;
    logic [FLW_WORD_W-1:0] mem_rdata;
    logic [FLW_ROW_W-1:0] row_cur;
    logic [5:0] prog_seen_q;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ****************************************
    // Latch bank
    // ****************************************
    flw_latch_mem #(
        .WIDTH(FLW_WORD_W),
        .DEPTH(FLW_LATCH_COUNT),
        .IDX_W(FLW_LATCH_IDX_W)
    ) u_latch (
        .hclk(hclk),
        .hresetn(hresetn),
        .we(mem_we),
        .wr_idx(addr_low_q[FLW_LATCH_IDX_W-1:0]),
        .wdata({data_high_q, data_low_q}),
        .clear(mem_clear),
        .rd_idx(cnt_q),
        .rdata(mem_rdata)
    );

    // ****************************************
    // Address phase capture
    // ****************************************
    always_comb
    begin
        ph_d = ph_q;
        if (hready)
        begin
            ph_d.valid = hsel && htrans == FLW_HTRANS_NONSEQ;
            ph_d.write = hwrite;
            ph_d.addr = haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ph_q <= '0;
        else
            ph_q <= ph_d;
    end

    // ****************************************
    // Registers, unlock key and sequencer
    // ****************************************
    always_comb
    begin
        addr_low_d = addr_low_q;
        addr_high_d = addr_high_q;
        data_low_d = data_low_q;
        data_high_d = data_high_q;
        ctl_d = ctl_q;
        key_d = key_q;
        st_d = st_q;
        cnt_d = cnt_q;
        wait_d = wait_q;
        row_d = row_q;
        prot_d = prot_q;
        irq_st_d = irq_st_q;
        mask_d = mask_q;
        flash_d = '0;
        mem_we = 1'b0;
        mem_clear = 1'b0;
        done_ev = 1'b0;
        refuse_ev = 1'b0;
        trig = 1'b0;
        row_cur = {addr_high_q, addr_low_q[FLW_ROW_LOW_MSB:FLW_ROW_LOW_LSB]};
        wr_acc = ph_q.valid && ph_q.write && hready;
        if (wr_acc)
        begin
            // Any write other than the next key step breaks the sequence
            key_d = KEY_IDLE;
            if (ph_q.addr == FLW_OFF_UNLOCK_KEY && hwdata[7:0] == FLW_KEY_FIRST)
                key_d = KEY_GOT_FIRST;
            else if (ph_q.addr == FLW_OFF_UNLOCK_KEY && hwdata[7:0] == FLW_KEY_SECOND
                     && key_q == KEY_GOT_FIRST)
                key_d = KEY_ARMED;
            unique case (ph_q.addr)
                FLW_OFF_ADDR_LOW: addr_low_d = hwdata[FLW_ADDR_LOW_W-1:0];
                FLW_OFF_ADDR_HIGH: addr_high_d = hwdata[FLW_ADDR_HIGH_W-1:0];
                FLW_OFF_DATA_LOW: data_low_d = hwdata[FLW_DATA_LOW_W-1:0];
                FLW_OFF_DATA_HIGH: data_high_d = hwdata[FLW_DATA_HIGH_W-1:0];
                FLW_OFF_CONTROL_ONE:
                begin
                    ctl_d = flw_ctl_s'(hwdata[FLW_CTL_W-1:0]);
                    ctl_d.write_start = ctl_q.write_start;
                    trig = key_q == KEY_ARMED && hwdata[FLW_CTL_WRITE_START_BIT];
                end
                FLW_OFF_IRQ_STATUS: irq_st_d = irq_st_q & ~hwdata[FLW_IRQ_W-1:0];
                FLW_OFF_IRQ_MASK: mask_d = hwdata[FLW_IRQ_W-1:0];
                FLW_OFF_PROTECT: prot_d = hwdata[FLW_ROW_W-1:0];
                default: ;
            endcase
        end
        unique case (st_q)
            ST_IDLE:
            begin
                if (trig && ctl_d.write_enable_bit)
                begin
                    if (ctl_d.region_select_bit || row_cur < prot_q)
                        refuse_ev = 1'b1;
                    else if (ctl_d.erase_select)
                    begin
                        flash_d.erase = 1'b1;
                        flash_d.row = row_cur;
                        row_d = row_cur;
                        ctl_d.write_start = 1'b1;
                        wait_d = '0;
                        st_d = ST_WAIT;
                    end
                    else
                    begin
                        mem_we = 1'b1;
                        row_d = row_cur;
                        ctl_d.write_start = 1'b1;
                        cnt_d = '0;
                        st_d = ctl_d.latch_only_mode ? ST_LOAD : ST_PROG_RD;
                    end
                end
            end
            ST_LOAD:
            begin
                ctl_d.write_start = 1'b0;
                st_d = ST_IDLE;
            end
            ST_PROG_RD: st_d = ST_PROG_WR;
            ST_PROG_WR:
            begin
                flash_d.prog = 1'b1;
                flash_d.row = row_q;
                flash_d.col = cnt_q;
                flash_d.data = mem_rdata;
                cnt_d = cnt_q + 5'h1;
                if (cnt_q == FLW_LAST_LATCH)
                begin
                    wait_d = '0;
                    st_d = ST_WAIT;
                end
                else
                    st_d = ST_PROG_RD;
            end
            ST_WAIT:
            begin
                wait_d = wait_q + 16'h1;
                if (wait_q >= FLW_WAIT_W'(OP_WAIT - 1))
                    st_d = ST_DONE;
            end
            ST_DONE:
            begin
                mem_clear = 1'b1;
                done_ev = 1'b1;
                ctl_d.write_start = 1'b0;
                st_d = ST_IDLE;
            end
        endcase
        // Hardware set beats a clear written in the same cycle
        irq_st_d[FLW_IRQ_DONE_BIT] = irq_st_d[FLW_IRQ_DONE_BIT] | done_ev;
        irq_st_d[FLW_IRQ_REFUSED_BIT] = irq_st_d[FLW_IRQ_REFUSED_BIT] | refuse_ev;
        irq_d = |(irq_st_d & mask_d);
        stall_d = st_d != ST_IDLE;
        hreadyout_d = st_d == ST_IDLE;
        hresp_d = FLW_HRESP_OKAY;
        hrdata_d = hrdata_q;
        if (hready && hsel && htrans == FLW_HTRANS_NONSEQ && !hwrite)
        begin
            unique case (haddr)
                FLW_OFF_ADDR_LOW: hrdata_d = 32'(addr_low_d);
                FLW_OFF_ADDR_HIGH: hrdata_d = 32'(addr_high_d);
                FLW_OFF_DATA_LOW: hrdata_d = 32'(data_low_d);
                FLW_OFF_DATA_HIGH: hrdata_d = 32'(data_high_d);
                FLW_OFF_CONTROL_ONE: hrdata_d = 32'(ctl_d);
                FLW_OFF_IRQ_STATUS: hrdata_d = 32'(irq_st_d);
                FLW_OFF_IRQ_MASK: hrdata_d = 32'(mask_d);
                FLW_OFF_PROTECT: hrdata_d = 32'(prot_d);
                default: hrdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_low_q <= '0;
            addr_high_q <= '0;
            data_low_q <= '0;
            data_high_q <= '0;
            ctl_q <= '0;
            key_q <= KEY_IDLE;
            st_q <= ST_IDLE;
            cnt_q <= '0;
            wait_q <= '0;
            row_q <= '0;
            prot_q <= FLW_PROTECT_RESET;
            irq_st_q <= '0;
            mask_q <= '0;
            flash_q <= '0;
            hrdata_q <= '0;
            hreadyout_q <= 1'b1;
            hresp_q <= FLW_HRESP_OKAY;
            irq_q <= 1'b0;
            stall_q <= 1'b0;
        end
        else
        begin
            addr_low_q <= addr_low_d;
            addr_high_q <= addr_high_d;
            data_low_q <= data_low_d;
            data_high_q <= data_high_d;
            ctl_q <= ctl_d;
            key_q <= key_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            wait_q <= wait_d;
            row_q <= row_d;
            prot_q <= prot_d;
            irq_st_q <= irq_st_d;
            mask_q <= mask_d;
            flash_q <= flash_d;
            hrdata_q <= hrdata_d;
            hreadyout_q <= hreadyout_d;
            hresp_q <= hresp_d;
            irq_q <= irq_d;
            stall_q <= stall_d;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign irq = irq_q;
    assign cpu_stall = stall_q;
    assign flash_cmd = flash_q;

    // ****************************************
    // Checks
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            prog_seen_q <= '0;
        else if (st_q == ST_IDLE)
            prog_seen_q <= '0;
        else if (flash_q.prog)
            prog_seen_q <= prog_seen_q + 6'h1;
    end

    property p_wr_needs_key;
        $rose(ctl_q.write_start) |-> $past(key_q) == KEY_ARMED;
    endproperty
    a_wr_needs_key: assert property (p_wr_needs_key) else $error("start without unlock");

    property p_wr_needs_enable;
        $rose(ctl_q.write_start) |-> ctl_q.write_enable_bit && !ctl_q.region_select_bit;
    endproperty
    a_wr_needs_enable: assert property (p_wr_needs_enable) else $error("start while disabled");

    property p_latch_only;
        st_q == ST_LOAD |=> st_q == ST_IDLE && !ctl_q.write_start && !flash_q.prog;
    endproperty
    a_latch_only: assert property (p_latch_only) else $error("latch load misbehaved");

    property p_prog_starts;
        $rose(ctl_q.write_start) && !ctl_q.latch_only_mode && !ctl_q.erase_select
        |-> ##2 flash_q.prog && flash_q.col == '0;
    endproperty
    a_prog_starts: assert property (p_prog_starts) else $error("program did not start");

    property p_prog_count;
        st_q == ST_DONE && !ctl_q.erase_select |-> prog_seen_q == 6'(FLW_LATCH_COUNT);
    endproperty
    a_prog_count: assert property (p_prog_count) else $error("wrong number of words");

    property p_row_select;
        $rose(ctl_q.write_start) |-> row_q == $past(row_cur);
    endproperty
    a_row_select: assert property (p_row_select) else $error("row not from address");

    property p_prog_row;
        flash_q.prog |-> flash_q.row == row_q && stall_q;
    endproperty
    a_prog_row: assert property (p_prog_row) else $error("program left its row");

    property p_protect;
        refuse_ev |=> !ctl_q.write_start && st_q == ST_IDLE && irq_st_q[FLW_IRQ_REFUSED_BIT];
    endproperty
    a_protect: assert property (p_protect) else $error("protected target not refused");

    property p_done_irq;
        st_q == ST_DONE |=> irq_st_q[FLW_IRQ_DONE_BIT] && !stall_q && hreadyout_q
        && (irq_q || !mask_q[FLW_IRQ_DONE_BIT]);
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("done flag or irq missing");

    property p_clear_start;
        st_q == ST_DONE |=> !ctl_q.write_start;
    endproperty
    a_clear_start: assert property (p_clear_start) else $error("start bit not cleared");

    property p_erase_row;
        flash_q.erase |-> !flash_q.prog && st_q == ST_WAIT && row_q == flash_q.row;
    endproperty
    a_erase_row: assert property (p_erase_row) else $error("erase not on whole row");

    c_latch_load: cover property (st_q == ST_LOAD);
    c_prog_done: cover property (st_q == ST_DONE && !ctl_q.erase_select);
    c_erase: cover property (flash_q.erase);
    c_refused: cover property (refuse_ev);

endmodule

// ---- shared/flw_pkg.sv ----
// Constants, types and register map of the flash row latch writer.
// Assumes one AHB-Lite bus clock at 50 MHz and 32-bit word registers.
package flw_pkg;

    // ****************************************
    // Bus
    // ****************************************
    localparam int FLW_HADDR_W = 8;
    localparam logic [1:0] FLW_HTRANS_NONSEQ = 2'h2;
    localparam logic FLW_HRESP_OKAY = 1'h0;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] FLW_OFF_ADDR_LOW = 8'h00;
    localparam logic [7:0] FLW_OFF_ADDR_HIGH = 8'h04;
    localparam logic [7:0] FLW_OFF_DATA_LOW = 8'h08;
    localparam logic [7:0] FLW_OFF_DATA_HIGH = 8'h0C;
    localparam logic [7:0] FLW_OFF_CONTROL_ONE = 8'h10;
    localparam logic [7:0] FLW_OFF_UNLOCK_KEY = 8'h14;
    localparam logic [7:0] FLW_OFF_IRQ_STATUS = 8'h18;
    localparam logic [7:0] FLW_OFF_IRQ_MASK = 8'h1C;
    localparam logic [7:0] FLW_OFF_PROTECT = 8'h20;

    // ****************************************
    // Fields and widths
    // ****************************************
    localparam int FLW_ADDR_HIGH_W = 7;
    localparam int FLW_ADDR_LOW_W = 8;
    localparam int FLW_DATA_HIGH_W = 6;
    localparam int FLW_DATA_LOW_W = 8;
    localparam int FLW_WORD_W = 14;
    localparam int FLW_LATCH_IDX_W = 5;
    localparam int FLW_LATCH_COUNT = 32;
    localparam int FLW_ROW_W = 10;
    localparam int FLW_ROW_LOW_MSB = 7;
    localparam int FLW_ROW_LOW_LSB = 5;
    localparam logic [4:0] FLW_LAST_LATCH = 5'h1F;
    localparam logic [13:0] FLW_BLANK_WORD = 14'h3FFF;
    localparam logic [7:0] FLW_KEY_FIRST = 8'h55;
    localparam logic [7:0] FLW_KEY_SECOND = 8'hAA;
    localparam int FLW_CTL_W = 5;
    localparam int FLW_CTL_WRITE_START_BIT = 0;
    localparam int FLW_IRQ_W = 2;
    localparam int FLW_IRQ_DONE_BIT = 0;
    localparam int FLW_IRQ_REFUSED_BIT = 1;
    localparam logic [9:0] FLW_PROTECT_RESET = 10'h000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int FLW_CLK_PERIOD_NS = 20;
    localparam int FLW_OP_TIME_NS = 2000;
    localparam int FLW_OP_WAIT_CYCLES = (FLW_OP_TIME_NS + FLW_CLK_PERIOD_NS - 1) / FLW_CLK_PERIOD_NS;
    localparam int FLW_WAIT_W = 16;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} flw_key_e;
    typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_PROG_RD, ST_PROG_WR, ST_WAIT, ST_DONE} flw_state_e;

    typedef struct packed {
        logic region_select_bit;
        logic erase_select;
        logic latch_only_mode;
        logic write_enable_bit;
        logic write_start;
    } flw_ctl_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [FLW_HADDR_W-1:0] addr;
    } flw_ph_s;

    typedef struct packed {
        logic prog;
        logic erase;
        logic [FLW_ROW_W-1:0] row;
        logic [FLW_LATCH_IDX_W-1:0] col;
        logic [FLW_WORD_W-1:0] data;
    } flw_flash_s;

endpackage

// ---- design/flw_latch_mem.sv ----
// Bank of row write latches with one write port, a clear-to-blank and a registered read.
// Assumes write and clear never need the same cycle; clear wins if they meet.
`timescale 1ns/100ps
module flw_latch_mem
    import flw_pkg::*;
#(
    parameter int WIDTH = FLW_WORD_W,
    parameter int DEPTH = FLW_LATCH_COUNT,
    parameter int IDX_W = FLW_LATCH_IDX_W
)
(
    input wire logic hclk,                  // Bus clock
    input wire logic hresetn,               // Async reset, low active
    input wire logic we,                    // Load one latch
    input wire logic [IDX_W-1:0] wr_idx,    // Latch to load
    input wire logic [WIDTH-1:0] wdata,     // Word to load
    input wire logic clear,                 // Set all latches blank
    input wire logic [IDX_W-1:0] rd_idx,    // Latch to read
    output logic [WIDTH-1:0] rdata          // Read word, one cycle late
);

    logic [WIDTH-1:0] entry_q [DEPTH];
    logic [WIDTH-1:0] entry_d [DEPTH];
    logic [WIDTH-1:0] rdata_q;
    logic [WIDTH-1:0] rdata_d;

    // ****************************************
    // Latch entries
    // ****************************************
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        always_comb
        begin
            entry_d[i] = entry_q[i];
            if (clear)
                entry_d[i] = WIDTH'(FLW_BLANK_WORD);
            else if (we && wr_idx == IDX_W'(i))
                entry_d[i] = wdata;
        end

        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
                entry_q[i] <= WIDTH'(FLW_BLANK_WORD);
            else
                entry_q[i] <= entry_d[i];
        end
    end

    always_comb
    begin
        rdata_d = entry_q[rd_idx];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_q <= '0;
        else
            rdata_q <= rdata_d;
    end

    assign rdata = rdata_q;

    // ****************************************
    // Checks
    // ****************************************
    property p_clear_blank;
        @(posedge hclk) disable iff (!hresetn)
        clear |=> entry_q[0] == WIDTH'(FLW_BLANK_WORD) && entry_q[DEPTH-1] == WIDTH'(FLW_BLANK_WORD);
    endproperty
    a_clear_blank: assert property (p_clear_blank) else $error("latches not blank after clear");

    property p_load_word;
        @(posedge hclk) disable iff (!hresetn)
        we && !clear |=> entry_q[$past(wr_idx)] == $past(wdata);
    endproperty
    a_load_word: assert property (p_load_word) else $error("latch did not take data word");

endmodule

// ---- dv/test_flw_row_latch_writer.sv ----
// Self-checking bench of the flash row latch writer: bus tasks, latch model and scenarios.
// Assumes the block is the only AHB-Lite slave, so hready loops back from hreadyout.
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_flw_row_latch_writer
    import flw_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic cpu_stall;
    flw_flash_s flash_cmd;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 32'h7A29;
    int erases = 0;
    int erow = 0;
    int lat[32];
    int pq[$];
    int r;
    int m;
    logic [31:0] rd;

    flw_row_latch_writer #(.OP_WAIT(2)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .cpu_stall(cpu_stall), .flash_cmd(flash_cmd));

    always #10 hclk = ~hclk;

    // ****************************************
    // Flash command monitor and timeout
    // ****************************************
    always @(posedge hclk)
    begin
        cycles++;
        if (flash_cmd.prog === 1'b1)
        begin
            pq.push_back({flash_cmd.row, flash_cmd.col, flash_cmd.data});
            `CHK(cpu_stall, 1'b1)
        end
        if (flash_cmd.erase === 1'b1)
        begin
            erases++;
            erow = flash_cmd.row;
        end
        if (cycles == 20000)
        begin
            fail_count++;
            results();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic results();
        $display("checks %0d fails %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One single transfer; entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= FLW_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    task automatic settle();
        repeat (2) @(posedge hclk);
    endtask

    task automatic unlock(input int ctl);
        wr(FLW_OFF_UNLOCK_KEY, {24'h0, FLW_KEY_FIRST});
        wr(FLW_OFF_UNLOCK_KEY, {24'h0, FLW_KEY_SECOND});
        wr(FLW_OFF_CONTROL_ONE, 32'(ctl | 1));
    endtask

    // Model takes the word only when write enable is set
    task automatic load(input int row, input int idx, input int v, input int ctl);
        wr(FLW_OFF_ADDR_HIGH, 32'(row >> 3));
        wr(FLW_OFF_ADDR_LOW, 32'(((row & 7) << 5) | idx));
        wr(FLW_OFF_DATA_LOW, 32'(v & 255));
        wr(FLW_OFF_DATA_HIGH, 32'(v >> 8));
        unlock(ctl);
        if (ctl & 2)
            lat[idx] = v;
    endtask

    // Done flag held in status: raise, mask and clear the interrupt
    task automatic irqchk();
        `CHK(irq, 1'b0)
        wr(FLW_OFF_IRQ_MASK, 32'h1);
        settle();
        `CHK(irq, 1'b1)
        wr(FLW_OFF_IRQ_STATUS, 32'h1);
        settle();
        `CHK(irq, 1'b0)
        rdchk(FLW_OFF_IRQ_STATUS, 32'h0);
        wr(FLW_OFF_IRQ_MASK, 32'h0);
    endtask

    task automatic progchk(input int row);
        rdchk(FLW_OFF_IRQ_STATUS, 32'h1);
        rdchk(FLW_OFF_CONTROL_ONE, 32'h2);
        `CHK(pq.size(), 32)
        for (int i = 0; i < pq.size(); i++)
            `CHK(pq[i], (row << 19) | (i << 14) | lat[i])
        irqchk();
        pq.delete();
        for (int i = 0; i < 32; i++)
            lat[i] = 16383;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        for (int i = 0; i < 32; i++)
            lat[i] = 16383;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(FLW_OFF_CONTROL_ONE, 32'h0);
        rdchk(FLW_OFF_PROTECT, 32'h0);
        rdchk(8'h24, 32'h0);
        `CHK(hresp, FLW_HRESP_OKAY)
        $display("test reset done");
        for (int k = 0; k < 2; k++)
        begin
            r = (k == 0) ? ($random(seed) & 1023) : 1023;
            m = $random(seed);
            wr(FLW_OFF_CONTROL_ONE, 32'h6);
            for (int i = 0; i < 31; i++)
                if (m[i])
                    load(r, i, $random(seed) & 16383, 6);
            `CHK(pq.size(), 0)
            load(r, 31, $random(seed) & 16383, 2);
            progchk(r);
            $display("test program round %0d done", k);
        end
        r = $random(seed) & 1023;
        load(r, 3, 32'h1234, 4);
        wr(FLW_OFF_UNLOCK_KEY, {24'h0, FLW_KEY_FIRST});
        wr(FLW_OFF_UNLOCK_KEY, {24'h0, FLW_KEY_SECOND});
        wr(FLW_OFF_DATA_LOW, 32'h5A);
        wr(FLW_OFF_CONTROL_ONE, 32'h7);
        `CHK(pq.size(), 0)
        load(r, 31, $random(seed) & 16383, 2);
        progchk(r);
        $display("test broken unlock done");
        r = $random(seed) & 511;
        wr(FLW_OFF_PROTECT, 32'(r + 1));
        load(r, 31, 32'h0ABC, 2);
        lat[31] = 16383;
        rdchk(FLW_OFF_IRQ_STATUS, 32'h2);
        rdchk(FLW_OFF_CONTROL_ONE, 32'h2);
        `CHK(pq.size(), 0)
        wr(FLW_OFF_IRQ_STATUS, 32'h2);
        wr(FLW_OFF_PROTECT, 32'h0);
        $display("test protect done");
        wr(FLW_OFF_ADDR_HIGH, 32'h7F);
        unlock(10);
        rdchk(FLW_OFF_IRQ_STATUS, 32'h1);
        `CHK(erases, 1)
        `CHK(erow, 1016 | (r & 7))
        `CHK(pq.size(), 0)
        irqchk();
        $display("test erase done");
        results();
    end
endmodule
